// >>> hdl/ipr_pkg.sv
// constants, register map and helpers for the inductive probe readout
// Function
// [R1] frame strobe snapshots inputs for next read
// [R2] latch mode adds stored position timestamp
// [R3] timestamp taken from distributed clock time
// [R4] master picks cycle from layout and carrier
// [R5] master cycle minimum without timestamps
// [R6] master cycle minimum with timestamps
// [R7] master watches cycle counter when faster
// [R8] master cycle is multiple of base time
// [R9] one carrier from first channel settings; the code sets it from the shared OFF_FREQ and OFF_VOLT registers
// [R10] carrier off until enable written true
// [R11] connection and impedance select principle
// [R12] gain from voltage sensitivity and range
// [R13] position reported in nanometres
// [R14] connection codes 4 5 6 13 15
// [R15] impedance codes 0 1 2
// [R16] carrier frequency only predefined hertz values
// [R17] two bit counter advances per new measurement
// [R18] position status counter updated together
package ipr_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CH_N = 2;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned FRAC_SHIFT = 15;
  localparam int unsigned POS_W = 32;
  localparam int unsigned TS_W = 64;
  localparam int unsigned FREQ_W = 15;
  localparam int unsigned HALF_W = 17;
  localparam int unsigned VOLT_W = 16;
  localparam int unsigned SENS_W = 16;
  localparam int unsigned SPAN_W = 16;
  localparam int unsigned SPAN_NM_W = 27;
  localparam int unsigned MAXSIG_W = 48;
  localparam int unsigned PROD_W = 48;
  localparam int unsigned ST_W = 8;
  localparam int unsigned NM_PER_UM = 1000;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_FREQ = 12'h004;
  localparam logic [11:0] OFF_VOLT = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [7:0] CH_PAGE0 = 8'h01;
  localparam logic [3:0] CH_CONN = 4'h0;
  localparam logic [3:0] CH_SENS = 4'h4;
  localparam logic [3:0] CH_SPAN = 4'h8;
  localparam logic [3:0] CH_FSCALE = 4'hC;
  // field positions
  localparam int unsigned CTRL_EXC_BIT = 0;
  localparam int unsigned CTRL_LATCH_BIT = 1;
  localparam int unsigned IMP_LSB = 4;
  localparam int unsigned ST_UNDER = 0;
  localparam int unsigned ST_OVER = 1;
  localparam int unsigned ST_EXC_ERR = 2;
  localparam int unsigned ST_CNT_LSB = 4;
  localparam int unsigned STAT_CNT_LSB = 8;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [14:0] FREQ_RST = 15'h1388;
  localparam logic [15:0] VOLT_RST = 16'h03E8;
  localparam logic [15:0] SENS_RST = 16'h0000;
  localparam logic [15:0] SPAN_RST = 16'h0000;
  // connection and impedance codes
  localparam logic [3:0] CONN_LVDT4 = 4'h4;
  localparam logic [3:0] CONN_LVDT5 = 4'h5;
  localparam logic [3:0] CONN_LVDT6 = 4'h6;
  localparam logic [3:0] CONN_HB3 = 4'hD;
  localparam logic [3:0] CONN_HB5 = 4'hF;
  localparam logic [1:0] IMP_HIGH = 2'h0;
  localparam logic [1:0] IMP_ALT1 = 2'h1;
  localparam logic [1:0] IMP_ALT2 = 2'h2;

  // half carrier period in clocks, zero for an unsupported frequency
  function automatic logic [HALF_W-1:0] ipr_half_period(input logic [FREQ_W-1:0] f);
    case (f)
      15'h03E8: ipr_half_period = HALF_W'(CLK_HZ / (2 * 1000));
      15'h07D0: ipr_half_period = HALF_W'(CLK_HZ / (2 * 2000));
      15'h09C4: ipr_half_period = HALF_W'(CLK_HZ / (2 * 2500));
      15'h0FA0: ipr_half_period = HALF_W'(CLK_HZ / (2 * 4000));
      15'h1388: ipr_half_period = HALF_W'(CLK_HZ / (2 * 5000));
      15'h1D4C: ipr_half_period = HALF_W'(CLK_HZ / (2 * 7500));
      15'h2710: ipr_half_period = HALF_W'(CLK_HZ / (2 * 10000));
      15'h30D4: ipr_half_period = HALF_W'(CLK_HZ / (2 * 12500));
      15'h32C8: ipr_half_period = HALF_W'(CLK_HZ / (2 * 13000));
      15'h3A98: ipr_half_period = HALF_W'(CLK_HZ / (2 * 15000));
      15'h4BC8: ipr_half_period = HALF_W'(CLK_HZ / (2 * 19400));
      15'h4E20: ipr_half_period = HALF_W'(CLK_HZ / (2 * 20000));
      default: ipr_half_period = '0;
    endcase
  endfunction
endpackage

// >>> hdl/ipr_chan_if.sv
// settings and results passed between the top and one probe channel
`timescale 1ns/10ps
interface ipr_chan_if;
  import ipr_pkg::*;
  logic excite_en;
  logic latch_mode;
  logic frame_start;
  logic [TS_W-1:0] dc_time;
  logic [VOLT_W-1:0] volt;
  logic [SENS_W-1:0] sens;
  logic [SPAN_W-1:0] span;
  logic [MAXSIG_W-1:0] max_sig;
  logic [POS_W-1:0] pos;
  logic [ST_W-1:0] status;
  logic [POS_W-1:0] latch_val;
  logic [TS_W-1:0] latch_ts;
  modport ctl (output excite_en, latch_mode, frame_start, dc_time, volt, sens, span,
    input max_sig, pos, status, latch_val, latch_ts);
  modport chan (input excite_en, latch_mode, frame_start, dc_time, volt, sens, span,
    output max_sig, pos, status, latch_val, latch_ts);
endinterface

// >>> hdl/ipr_channel.sv
// one probe channel: scaling, staging, latch capture and frame snapshot
`timescale 1ns/10ps
module ipr_channel (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // settings and results
  ipr_chan_if.chan cif,
  // converter samples, same clock
  input wire logic adc_valid,
  input wire logic [ipr_pkg::SAMPLE_W-1:0] adc_sample,
  // latch pin, asynchronous
  input wire logic latch_pin
);
  import ipr_pkg::*;

  logic [MAXSIG_W-1:0] max_sig_r;
  logic [SPAN_NM_W-1:0] span_nm;
  logic signed [SAMPLE_W-1:0] smp;
  logic signed [PROD_W-1:0] prod;
  logic [POS_W-1:0] pos_stage_r, pos_r, lat_val_stage_r, lat_val_r;
  logic [2:0] st_stage_r;
  logic [ST_W-1:0] status_r;
  logic [1:0] cnt_r;
  logic new_r;
  logic [TS_W-1:0] lat_ts_stage_r, lat_ts_r;
  logic sync1_r, sync2_r, sync3_r;
  logic latch_rise;

  ////////////////////////////////////////////////////////////////////////////
  // full scale signal in nV; read back through CH_FSCALE, refreshed every clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      max_sig_r <= '0;
    else
      max_sig_r <= MAXSIG_W'(cif.volt) * MAXSIG_W'(cif.sens) * MAXSIG_W'(cif.span); // R12
  end

  // a full scale sample maps onto the whole probe travel
  assign span_nm = SPAN_NM_W'(cif.span) * SPAN_NM_W'(NM_PER_UM);
  assign smp = adc_sample;
  assign prod = PROD_W'(smp) * $signed(PROD_W'(span_nm));

  ////////////////////////////////////////////////////////////////////////////
  // staging: latest result, held until the next frame picks it up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_stage_r <= '0;
      st_stage_r <= '0;
    end
    else if (adc_valid)
    begin
      pos_stage_r <= prod[POS_W+FRAC_SHIFT-1:FRAC_SHIFT]; // R13
      st_stage_r[ST_UNDER] <= (adc_sample == {1'b1, {(SAMPLE_W-1){1'b0}}});
      st_stage_r[ST_OVER] <= (adc_sample == {1'b0, {(SAMPLE_W-1){1'b1}}});
      st_stage_r[ST_EXC_ERR] <= !cif.excite_en;
    end
  end

  // fresh marker: a sample in the snapshot cycle survives for the next frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      new_r <= 1'b0;
    else if (adc_valid)
      new_r <= 1'b1; // R17
    else if (cif.frame_start)
      new_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch pin synchroniser; the second and third stages feed the edge detector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end
    else
    begin
      sync1_r <= latch_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  assign latch_rise = sync2_r && !sync3_r;

  // latch capture, stamped with distributed clock time, not a local count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lat_val_stage_r <= '0;
      lat_ts_stage_r <= '0;
    end
    else if (!cif.latch_mode)
      lat_ts_stage_r <= '0;
    else if (latch_rise)
    begin
      lat_val_stage_r <= pos_stage_r; // R2
      lat_ts_stage_r <= cif.dc_time; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame snapshot: all values move at one edge so no read mixes results
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_r <= '0;
      status_r <= '0;
      cnt_r <= '0;
      lat_val_r <= '0;
      lat_ts_r <= '0;
    end
    else if (cif.frame_start)
    begin
      pos_r <= pos_stage_r; // R1 R18
      status_r <= ST_W'({cnt_r + 2'(new_r), 1'b0, st_stage_r}); // R18
      cnt_r <= cnt_r + 2'(new_r); // R17
      lat_val_r <= lat_val_stage_r;
      lat_ts_r <= lat_ts_stage_r; // R2
    end
  end

  assign cif.max_sig = max_sig_r;
  assign cif.pos = pos_r;
  assign cif.status = status_r;
  assign cif.latch_val = lat_val_r;
  assign cif.latch_ts = lat_ts_r;

  ////////////////////////////////////////////////////////////////////////////
  a_cnt_advance: assert property (@(posedge pclk) disable iff (!presetn) // R17
    cif.frame_start && new_r |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("counter did not advance on fresh data");
  a_cnt_hold: assert property (@(posedge pclk) disable iff (!presetn) // R17
    cif.frame_start && !new_r && !adc_valid |=> $stable(cnt_r))
    else $error("counter moved without fresh data");
  a_snap_atomic: assert property (@(posedge pclk) disable iff (!presetn) // R18
    cif.frame_start |=> pos_r == $past(pos_stage_r) && status_r[5:4] == cnt_r)
    else $error("snapshot mixed position and counter");
  a_pd_hold: assert property (@(posedge pclk) disable iff (!presetn) // R1
    !cif.frame_start |=> $stable(pos_r) && $stable(status_r))
    else $error("process data changed outside a frame");
  a_latch_stamp: assert property (@(posedge pclk) disable iff (!presetn) // R3
    cif.latch_mode && latch_rise |=> lat_ts_stage_r == $past(cif.dc_time))
    else $error("latch stamp not from distributed clock");
endmodule

// >>> hdl/ipr_top.sv
// two channel probe readout top: apb registers, carrier, process data
`timescale 1ns/10ps
module ipr_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [ipr_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fieldbus process data exchange
  input wire logic frame_start,
  input wire logic [ipr_pkg::TS_W-1:0] dc_time,
  output logic pd_update,
  output logic [ipr_pkg::CH_N-1:0][ipr_pkg::POS_W-1:0] pd_position,
  output logic [ipr_pkg::CH_N-1:0][ipr_pkg::ST_W-1:0] pd_status,
  output logic [ipr_pkg::CH_N-1:0][ipr_pkg::POS_W-1:0] pd_latch_val,
  output logic [ipr_pkg::CH_N-1:0][ipr_pkg::TS_W-1:0] pd_latch_ts,
  // converter samples and latch pins
  input wire logic [ipr_pkg::CH_N-1:0] adc_valid,
  input wire logic [ipr_pkg::CH_N-1:0][ipr_pkg::SAMPLE_W-1:0] adc_sample,
  input wire logic [ipr_pkg::CH_N-1:0] latch_pin,
  // shared carrier and per channel front-end selection
  output logic carrier_out_pos,
  output logic carrier_out_neg,
  output logic [ipr_pkg::VOLT_W-1:0] carrier_amp_mv,
  output logic [ipr_pkg::CH_N-1:0][3:0] fe_conn,
  output logic [ipr_pkg::CH_N-1:0][1:0] fe_imp,
  output logic [ipr_pkg::CH_N-1:0] fe_half_bridge
);
  import ipr_pkg::*;

  logic [1:0] ctrl_r;
  logic [FREQ_W-1:0] freq_r;
  logic [VOLT_W-1:0] volt_r;
  logic [3:0] conn_r [CH_N];
  logic [1:0] imp_r [CH_N];
  logic [CH_N-1:0] hb_r;
  logic [SENS_W-1:0] sens_r [CH_N];
  logic [SPAN_W-1:0] span_r [CH_N];
  logic [31:0] prdata_r;
  logic pd_update_r;
  logic [HALF_W-1:0] half_c, car_cnt_r;
  logic car_pos_r, car_neg_r;
  logic wr_en, rd_setup, page_hit, ch_sel;
  logic err_c, conn_ok, imp_ok;
  logic [31:0] rd_c;

  ipr_chan_if ch_if[CH_N] ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode; channel pages sit one after another
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign ch_sel = (paddr[11:4] != CH_PAGE0);
  assign page_hit = (paddr[11:4] == CH_PAGE0) || (paddr[11:4] == CH_PAGE0 + 8'h01);
  assign conn_ok = (pwdata[3:0] == CONN_LVDT4) || (pwdata[3:0] == CONN_LVDT5) || // R14
    (pwdata[3:0] == CONN_LVDT6) || (pwdata[3:0] == CONN_HB3) || (pwdata[3:0] == CONN_HB5);
  assign imp_ok = (pwdata[5:4] == IMP_HIGH) || (pwdata[5:4] == IMP_ALT1) || // R15
    (pwdata[5:4] == IMP_ALT2);

  // read mux and error answer; bad values are refused, not stored
  always_comb
  begin
    rd_c = '0;
    err_c = 1'b0;
    if (paddr[1:0] != 2'h0)
      err_c = 1'b1;
    else if (paddr == OFF_CTRL)
      rd_c = 32'(ctrl_r);
    else if (paddr == OFF_FREQ)
    begin
      rd_c = 32'(freq_r);
      err_c = pwrite && (ipr_half_period(pwdata[FREQ_W-1:0]) == '0 || pwdata[31:FREQ_W] != '0);
    end
    else if (paddr == OFF_VOLT)
      rd_c = 32'(volt_r);
    else if (paddr == OFF_STATUS)
    begin
      rd_c = {20'h0_0000, pd_status[1][5:4], pd_status[0][5:4], 7'h00, ctrl_r[CTRL_EXC_BIT]};
      err_c = pwrite;
    end
    else if (page_hit)
    begin
      case (paddr[3:0])
        CH_CONN:
        begin
          rd_c = 32'({imp_r[ch_sel], conn_r[ch_sel]});
          err_c = pwrite && !(conn_ok && imp_ok);
        end
        CH_SENS: rd_c = 32'(sens_r[ch_sel]);
        CH_SPAN: rd_c = 32'(span_r[ch_sel]);
        CH_FSCALE:
        begin
          rd_c = ch_if[0].max_sig[MAXSIG_W-1:16];
          if (ch_sel)
            rd_c = ch_if[1].max_sig[MAXSIG_W-1:16];
          err_c = pwrite;
        end
        default: err_c = 1'b1;
      endcase
    end
    else
      err_c = 1'b1;
  end

  // read data registered in the setup phase, so the access phase sees it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= '0;
    else if (rd_setup)
      prdata_r <= err_c ? 32'h0000_0000 : rd_c;
  end
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_c;

  ////////////////////////////////////////////////////////////////////////////
  // shared settings: carrier frequency and level held once for both channels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST; // R10
      freq_r <= FREQ_RST;
      volt_r <= VOLT_RST;
    end
    else if (wr_en && !err_c)
    begin
      if (paddr == OFF_CTRL)
        ctrl_r <= pwdata[1:0];
      if (paddr == OFF_FREQ)
        freq_r <= pwdata[FREQ_W-1:0]; // R16 R9
      if (paddr == OFF_VOLT)
        volt_r <= pwdata[VOLT_W-1:0]; // R9
    end
  end

  // per channel probe settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < CH_N; i++)
      begin
        conn_r[i] <= CONN_LVDT4;
        imp_r[i] <= IMP_HIGH;
        hb_r[i] <= 1'b0;
        sens_r[i] <= SENS_RST;
        span_r[i] <= SPAN_RST;
      end
    end
    else if (wr_en && !err_c && page_hit)
    begin
      case (paddr[3:0])
        CH_CONN:
        begin
          conn_r[ch_sel] <= pwdata[3:0]; // R11
          imp_r[ch_sel] <= pwdata[IMP_LSB+1:IMP_LSB]; // R11
          hb_r[ch_sel] <= (pwdata[3:0] == CONN_HB3) || (pwdata[3:0] == CONN_HB5); // R14
        end
        CH_SENS: sens_r[ch_sel] <= pwdata[SENS_W-1:0]; // R12
        CH_SPAN: span_r[ch_sel] <= pwdata[SPAN_W-1:0]; // R12
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carrier: square pair, idle low while disabled; a new frequency applies to
  // the half wave in progress, so a change may stretch or cut short one half wave
  assign half_c = ipr_half_period(freq_r);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      car_cnt_r <= '0;
      car_pos_r <= 1'b0;
      car_neg_r <= 1'b0;
    end
    else if (!ctrl_r[CTRL_EXC_BIT])
    begin
      car_cnt_r <= '0; // R10
      car_pos_r <= 1'b0;
      car_neg_r <= 1'b0;
    end
    else if (!car_pos_r && !car_neg_r)
      car_pos_r <= 1'b1;
    else if (car_cnt_r >= half_c - HALF_W'(1))
    begin
      car_cnt_r <= '0; // R9
      car_pos_r <= !car_pos_r;
      car_neg_r <= !car_neg_r;
    end
    else
      car_cnt_r <= car_cnt_r + HALF_W'(1);
  end
  assign carrier_out_pos = car_pos_r;
  assign carrier_out_neg = car_neg_r;
  assign carrier_amp_mv = volt_r;

  // marks the cycle in which the snapshot becomes visible
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pd_update_r <= 1'b0;
    else
      pd_update_r <= frame_start; // R1
  end
  assign pd_update = pd_update_r;

  ////////////////////////////////////////////////////////////////////////////
  // channels
  for (genvar g = 0; g < CH_N; g++)
  begin : g_ch
    assign ch_if[g].excite_en = ctrl_r[CTRL_EXC_BIT];
    assign ch_if[g].latch_mode = ctrl_r[CTRL_LATCH_BIT];
    assign ch_if[g].frame_start = frame_start;
    assign ch_if[g].dc_time = dc_time;
    assign ch_if[g].volt = volt_r;
    assign ch_if[g].sens = sens_r[g];
    assign ch_if[g].span = span_r[g];
    assign pd_position[g] = ch_if[g].pos;
    assign pd_status[g] = ch_if[g].status;
    assign pd_latch_val[g] = ch_if[g].latch_val;
    assign pd_latch_ts[g] = ch_if[g].latch_ts;
    assign fe_conn[g] = conn_r[g];
    assign fe_imp[g] = imp_r[g];
    assign fe_half_bridge[g] = hb_r[g];
    ipr_channel u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .cif(ch_if[g]),
      .adc_valid(adc_valid[g]),
      .adc_sample(adc_sample[g]),
      .latch_pin(latch_pin[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  a_carrier_off: assert property (@(posedge pclk) disable iff (!presetn) // R10
    !ctrl_r[CTRL_EXC_BIT] |=> !carrier_out_pos && !carrier_out_neg)
    else $error("carrier driven while disabled");
  a_carrier_anti: assert property (@(posedge pclk) disable iff (!presetn) // R9
    ctrl_r[CTRL_EXC_BIT] [*2] |=> carrier_out_pos != carrier_out_neg)
    else $error("carrier pair not complementary");
  a_freq_reject: assert property (@(posedge pclk) disable iff (!presetn) // R16
    wr_en && paddr == OFF_FREQ && ipr_half_period(pwdata[FREQ_W-1:0]) == '0
    |=> $stable(freq_r))
    else $error("unsupported frequency stored");
  a_conn_reject: assert property (@(posedge pclk) disable iff (!presetn) // R14
    wr_en && page_hit && paddr[3:0] == CH_CONN && !conn_ok |=> $stable(fe_conn))
    else $error("invalid connection code stored");
  a_pd_marker: assert property (@(posedge pclk) disable iff (!presetn) // R1
    frame_start |=> pd_update ##1 pd_update == $past(frame_start))
    else $error("update marker not one cycle after frame");
endmodule

// >>> verif/ipr_fb_master.sv
// fieldbus master model: frame pulses and distributed clock time
`timescale 1ns/10ps
module ipr_fb_master #(
  parameter int unsigned BASE_NS = 5
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // frame request from the bench
  input wire logic go,
  // process data exchange
  output logic frame_start,
  output logic [ipr_pkg::TS_W-1:0] dc_time
);
  import ipr_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // time base advances one base unit per clock, like a nanosecond system time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dc_time <= '0;
    else
      dc_time <= dc_time + TS_W'(BASE_NS);
  end
  // one frame per clock of go; the spacing is picked by the bench, whole clocks only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_start <= 1'b0;
    else
      frame_start <= go;
  end
endmodule

// >>> verif/inductive_probe_readout_sync_tb_top.sv
// self-checking bench for the two channel probe readout
`timescale 1ns/10ps
module inductive_probe_readout_sync_tb_top;
  import ipr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic go = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, pd_update, frame_start, carrier_out_pos, carrier_out_neg;
  logic [TS_W-1:0] dc_time;
  logic [TS_W-1:0] t0;
  logic [CH_N-1:0][POS_W-1:0] pd_position, pd_latch_val, pos_e;
  logic [CH_N-1:0][ST_W-1:0] pd_status;
  logic [CH_N-1:0][TS_W-1:0] pd_latch_ts;
  logic [CH_N-1:0] adc_valid = '0;
  logic [CH_N-1:0] latch_pin = '0;
  logic [CH_N-1:0][SAMPLE_W-1:0] adc_sample = '0;
  logic [VOLT_W-1:0] carrier_amp_mv;
  logic [CH_N-1:0][3:0] fe_conn;
  logic [CH_N-1:0][1:0] fe_imp;
  logic [CH_N-1:0] fe_half_bridge, fresh;
  logic [CH_N-1:0][1:0] cnt_e;
  logic [CH_N-1:0][15:0] span_e;
  logic [31:0] rnd = 32'h0001_264A;
  logic [15:0] freqs [12] = '{16'h03E8, 16'h07D0, 16'h09C4, 16'h0FA0, 16'h1388, 16'h1D4C,
    16'h2710, 16'h30D4, 16'h32C8, 16'h3A98, 16'h4BC8, 16'h4E20};
  logic [3:0] conns [5] = '{4'h4, 4'h5, 4'h6, 4'hD, 4'hF};
  logic [32:0] rq [$];
  logic [CH_N-1:0][POS_W+1:0] pq [$];
  int fails = 0;
  int tests_run = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  ipr_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_start(frame_start), .dc_time(dc_time), .pd_update(pd_update),
    .pd_position(pd_position), .pd_status(pd_status), .pd_latch_val(pd_latch_val),
    .pd_latch_ts(pd_latch_ts), .adc_valid(adc_valid), .adc_sample(adc_sample),
    .latch_pin(latch_pin), .carrier_out_pos(carrier_out_pos),
    .carrier_out_neg(carrier_out_neg), .carrier_amp_mv(carrier_amp_mv), .fe_conn(fe_conn),
    .fe_imp(fe_imp), .fe_half_bridge(fe_half_bridge));
  ipr_fb_master i_master (.pclk(pclk), .presetn(presetn), .go(go),
    .frame_start(frame_start), .dc_time(dc_time));
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one apb transfer; the answer is judged by the bus monitor
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    input logic [32:0] e);
    rq.push_back(e);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(a, 1'b1, d, {err, 32'h0000_0000});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(a, 1'b0, 32'h0000_0000, {err, d});
  endtask
  // a random converter sample; expected nanometres follow from the channel span
  task automatic sample(input int c);
    logic [15:0] s;
    logic signed [63:0] p;
    rnd = lfsr(rnd);
    s = rnd[15:0];
    p = ($signed(s) * $signed({1'b0, span_e[c]}) * int'(NM_PER_UM)) >>> 15;
    @(posedge pclk);
    adc_valid[c] <= 1'b1;
    adc_sample[c] <= s;
    @(posedge pclk);
    adc_valid[c] <= 1'b0;
    pos_e[c] = p[31:0];
    fresh[c] = 1'b1;
  endtask
  // nf back to back frames; only the first sees fresh data
  task automatic frame(input int nf);
    logic [CH_N-1:0][POS_W+1:0] e;
    repeat (nf)
    begin
      for (int c = 0; c < CH_N; c++)
      begin
        cnt_e[c] = cnt_e[c] + 2'(fresh[c]);
        fresh[c] = 1'b0;
        e[c] = {cnt_e[c], pos_e[c]};
      end
      pq.push_back(e);
    end
    @(posedge pclk);
    go <= 1'b1;
    repeat (nf) @(posedge pclk);
    go <= 1'b0;
    for (int k = 0; k < 20 && pq.size() > 0; k++)
      @(posedge pclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // bus answers against the oldest noted expectation
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      check("pslverr", 64'(rq[0][32]), 64'(pslverr));
      if (!pwrite)
        check("prdata", 64'(rq[0][31:0]), 64'(prdata));
      void'(rq.pop_front());
    end
  // process data; an update with nothing noted shows up as a mismatch
  always @(posedge pclk)
    if (pd_update === 1'b1)
    begin
      check("noted frame", 64'(pq.size() != 0), 64'h1);
      for (int c = 0; c < CH_N; c++)
      begin
        check("position", 64'(pq[0][c][POS_W-1:0]), 64'(pd_position[c]));
        check("counter", 64'(pq[0][c][POS_W+1:POS_W]), 64'(pd_status[c][5:4]));
      end
      void'(pq.pop_front());
    end
  // watchdog, well past the expected run length
  initial
  begin
    #400_000;
    fails++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fresh = '0;
    cnt_e = '0;
    pos_e = '0;
    span_e = {16'h07D0, 16'h0064};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL, 32'h0000_0000, 1'b0);
    rd(OFF_FREQ, 32'h0000_1388, 1'b0);
    rd({CH_PAGE0, CH_CONN}, 32'h0000_0004, 1'b0);
    #1 check("carrier idle", 64'({carrier_out_pos, carrier_out_neg}), 64'h0);
    // every listed frequency, then one between entries which must be refused
    foreach (freqs[i])
    begin
      wr(OFF_FREQ, 32'(freqs[i]), 1'b0);
      rd(OFF_FREQ, 32'(freqs[i]), 1'b0);
    end
    wr(OFF_FREQ, 32'h0000_0BB8, 1'b1);
    rd(OFF_FREQ, 32'h0000_4E20, 1'b0);
    // every connection code with the impedance codes in turn, then bad codes
    foreach (conns[i])
    begin
      wr({CH_PAGE0 + 8'h01, CH_CONN}, {26'h0, 2'(i % 3), conns[i]}, 1'b0);
      #1 check("fe_conn", 64'(fe_conn[1]), 64'(conns[i]));
      check("fe_imp", 64'(fe_imp[1]), 64'(i % 3));
      check("half bridge", 64'(fe_half_bridge[1]), 64'(conns[i] > 4'h6));
    end
    wr({CH_PAGE0, CH_CONN}, 32'h0000_0007, 1'b1);
    wr({CH_PAGE0, CH_CONN}, 32'h0000_0034, 1'b1);
    rd(12'h0FC, 32'h0000_0000, 1'b1);
    wr({CH_PAGE0, CH_FSCALE}, 32'h0000_0001, 1'b1);
    // gain from voltage, sensitivity and span; voltage reaches the carrier
    wr(OFF_VOLT, 32'h0000_07D0, 1'b0);
    wr({CH_PAGE0, CH_SENS}, 32'h0000_0032, 1'b0);
    wr({CH_PAGE0, CH_SPAN}, 32'(span_e[0]), 1'b0);
    wr({CH_PAGE0 + 8'h01, CH_SPAN}, 32'(span_e[1]), 1'b0);
    rd({CH_PAGE0, CH_FSCALE}, 32'((64'h07D0 * 64'h32 * 64'h64) >> 16), 1'b0);
    #1 check("carrier amplitude", 64'(carrier_amp_mv), 64'h07D0);
    // carrier at 20 kHz: high for exactly one half period
    wr(OFF_CTRL, 32'h0000_0001, 1'b0);
    @(posedge pclk);
    #1 check("carrier on", 64'({carrier_out_pos, carrier_out_neg}), 64'h2);
    n = 0;
    while (carrier_out_pos === 1'b1 && n < 6000)
    begin
      @(posedge pclk);
      #1 n++;
    end
    check("half period", 64'(n), 64'h1388);
    check("carrier pair", 64'({carrier_out_pos, carrier_out_neg}), 64'h1);
    // process data: empty frame, fresh samples wrapping the counter, fast frames
    frame(1);
    repeat (5)
    begin
      sample(0);
      sample(1);
      frame(1);
    end
    check("stamp off", 64'(pd_latch_ts[0]), 64'h0);
    sample(0);
    frame(3);
    rd(OFF_STATUS, {20'h0_0000, cnt_e[1], cnt_e[0], 8'h01}, 1'b0);
    wr(OFF_STATUS, 32'h0000_0001, 1'b1);
    // latch with stamps on: value and stamp come with the same frame
    wr(OFF_CTRL, 32'h0000_0003, 1'b0);
    sample(0);
    @(posedge pclk);
    latch_pin[0] <= 1'b1;
    t0 = dc_time;
    repeat (6) @(posedge pclk);
    latch_pin[0] <= 1'b0;
    frame(1);
    #1 check("latch value", 64'(pd_latch_val[0]), 64'(pos_e[0]));
    check("latch stamp", 64'(pd_latch_ts[0]), t0 + 64'd15);
    wr(OFF_CTRL, 32'h0000_0000, 1'b0);
    @(posedge pclk);
    #1 check("carrier off", 64'({carrier_out_pos, carrier_out_neg}), 64'h0);
    check("pending", 64'(pq.size() + rq.size()), 64'h0);
    conclude();
  end
endmodule
